// ===== src/rbl_regs.svh
// constants for the reset boot mode loader
// assumes inclusion from the boot loader design file
`ifndef RBL_REGS_SVH
`define RBL_REGS_SVH
`define RBL_MODE_DIRECT 2'h0
`define RBL_MODE_FLASH 2'h1
`define RBL_MODE_SPIHOST 2'h2
`define RBL_MODE_EEPROM 2'h3
`define RBL_DIRECT_ADDR 32'h20000000
`define RBL_L1A_ADDR 32'hffa00000
`define RBL_L1B_ADDR 32'hff600000
`define RBL_SETUP_CYC 4'h4
`define RBL_ACCESS_CYC 4'hf
`define RBL_HOLD_CYC 4'h3
`define RBL_FLASH_BANK 2'h0
`define RBL_EE_READ_CMD 8'h03
`define RBL_EE_ADDR 24'h000000
`define RBL_FLAG_LSB 5
`define RBL_FLAG_MSB 10
`define RBL_SYSCR_HOLD_BIT 5
`define RBL_RCFG_SKIP_BIT 4
`define RBL_SCK_DIV 4'h3
`endif

// ===== src/rbl_pkg.sv
// types shared by the reset boot mode loader files
// assumes rbl_regs.svh on the include path
package rbl_pkg;
  typedef enum logic [1:0] {
    RBL_DIRECT, RBL_FLASH, RBL_SPIHOST, RBL_EEPROM
  } rbl_mode_t;
  typedef struct packed {
    logic [3:0] setupCyc;
    logic [3:0] accessCyc;
    logic [3:0] holdCyc;
    logic [1:0] bank;
    logic enable;
  } rbl_mem_cfg_t;
  typedef struct packed {
    logic valid;
    logic [31:0] addr;
    logic [7:0] data;
  } rbl_wr_t;
endpackage

// ===== src/rbl_spi_slave.sv
// spi slave receiver on the host clock, mode 0, msb first
// assumes the host keeps sck still between frames; bytes leave by toggle
`timescale 1ns/100ps
module rbl_spi_slave (
  input wire logic spiClk, // host serial clock
  input wire logic rst_n, // async reset, active low
  input wire logic selectN, // slave select, active low
  input wire logic mosi, // host data in
  output logic [7:0] byteData, // last full byte
  output logic byteToggle // flips once per byte
);
  logic [2:0] bitCnt;
  logic [6:0] shift;
  // frames carry whole bytes: deselect does not clear the bit count
  always_ff @(posedge spiClk or negedge rst_n) begin
    if (!rst_n) begin
      bitCnt <= 3'h0;
      shift <= 7'h00;
      byteData <= 8'h00;
      byteToggle <= 1'b0;
    end else if (!selectN) begin
      shift <= {shift[5:0], mosi};
      bitCnt <= bitCnt + 3'h1;
      if (bitCnt == 3'h7) begin
        byteData <= {shift, mosi};
        byteToggle <= ~byteToggle;
      end
    end
  end
endmodule // rbl_spi_slave

// ===== src/rbl_boot_loader.sv
// reset boot mode loader: picks a boot action from the mode pins,
// loads blocks from spi host, spi eeprom or flash, then releases cores.
// assumes memory writes complete in one cycle and flash is read by a
// separate bus unit that returns bytes as a strobe with data.
//
// What this block does
// - capture mode pins at power-on and software reset, use captured value
// - 00 direct, 01 flash, 10 spi host, 11 spi eeprom
// - direct mode skips boot rom, fetches at 0x20000000, 16-bit packing
// - direct and flash modes use 4 setup, 15 access, 3 hold cycles
// - direct mode lets only the first core fetch external memory
// - flash mode runs loader over async memory bank 0
// - spi host mode: device is slave, host masters the transfer
// - assert host-hold flag while busy, release when ready for bytes
// - host-hold flag number comes from bits 10:5 of flag header
// - eeprom mode drives select flag, reads from 0x0000 into l1
// - every loading mode copies any number of blocks to destinations
// - after last block first core starts at 0xffa00000
// - second core held until sysconfig bit 5 clears, then 0xff600000
// - reset config bit 4 makes software reset skip load, jump to l1
`timescale 1ns/100ps
`include "rbl_regs.svh"
module rbl_boot_loader (
  input wire logic sys_clk, // 25 mhz system clock
  input wire logic rst_n, // power-on reset, async, active low
  input wire logic softReset, // software reset pulse, sys_clk domain
  input wire logic [1:0] boot_select_pins, // boot mode pins
  input wire logic [7:0] core_a_system_config, // first core sysconfig
  input wire logic [7:0] resetConfigWrite, // reset config sw value
  input wire logic resetConfigWe, // reset config write strobe
  input wire logic eeAddr24, // eeprom uses 24-bit address
  input wire logic hostSpiClk, // host serial clock
  input wire logic hostSelectN, // host slave select, active low
  input wire logic hostMosi, // host data
  input wire logic eeMiso, // eeprom data in
  input wire logic flashByteValid, // flash byte strobe
  input wire logic [7:0] flashByte, // flash byte
  output logic flashReadReq, // ask flash unit for next byte
  output logic [31:0] flashAddr, // flash byte address
  output logic eeSck, // eeprom serial clock
  output logic eeMosi, // eeprom data out
  output logic eeprom_select_flag, // eeprom select, active low
  output logic [63:0] flagOut, // general flag outputs
  output logic [63:0] flagOeN, // flag output enables, low drives
  output rbl_pkg::rbl_wr_t memWrite, // load write to memory
  output rbl_pkg::rbl_mem_cfg_t memCfg, // async memory timing
  output logic [1:0] bootMode, // captured boot mode
  output logic [7:0] resetConfig, // reset config readback
  output logic coreARun, // first core released
  output logic [31:0] coreAStart, // first core start address
  output logic coreAExtFetch, // first core may fetch external
  output logic fetch16, // 16-bit packing for external fetch
  output logic coreBRun, // second core released
  output logic [31:0] coreBStart, // second core start address
  output logic coreBExtFetch, // second core may fetch external
  output logic bootDone // load finished
);
  import rbl_pkg::*;
  typedef enum logic [3:0] {
    ST_CAPTURE, ST_DISPATCH, ST_EE_CMD, ST_HDR, ST_DATA,
    ST_LAUNCH, ST_RUN
  } rbl_state_t;

  rbl_state_t state;
  logic [2:0] hdrCnt;
  logic [31:0] blkAddr;
  logic [15:0] blkCount;
  logic [15:0] blkFlags;
  logic [5:0] holdFlag;
  logic holdValid;
  logic [31:0] cmdShift;
  logic [5:0] cmdBits;
  logic [3:0] sckDiv;
  logic [7:0] eeShift;
  logic [2:0] eeBit;
  logic eeByteValid;
  logic [7:0] eeByte;
  logic [7:0] hostByte;
  logic hostToggle;
  logic [2:0] hostTogSync;
  logic [1:0] pinMeta;
  logic hostByteValid;
  logic inByteValid;
  logic [7:0] inByte;
  logic swPend;
  logic [1:0] sysSync;
  logic [1:0] pinSync;
  logic lastBlock;

  rbl_spi_slave hostRx (
    .spiClk(hostSpiClk),
    .rst_n(rst_n),
    .selectN(hostSelectN),
    .mosi(hostMosi),
    .byteData(hostByte),
    .byteToggle(hostToggle)
  );

  // toggle crossing; byte register is stable long before the toggle lands
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      hostTogSync <= 3'h0;
      sysSync <= 2'h3;
    end else begin
      hostTogSync <= {hostTogSync[1:0], hostToggle};
      sysSync <= {sysSync[0], core_a_system_config[`RBL_SYSCR_HOLD_BIT]};
    end
  end
  assign hostByteValid = hostTogSync[2] ^ hostTogSync[1];

  // mode pins sync through reset, so capture sees settled straps at release
  always_ff @(posedge sys_clk) begin
    pinMeta <= boot_select_pins;
    pinSync <= pinMeta;
  end

  always_comb begin
    inByteValid = 1'b0;
    inByte = 8'h00;
    case (bootMode)
      `RBL_MODE_FLASH: begin
        inByteValid = flashByteValid;
        inByte = flashByte;
      end
      `RBL_MODE_SPIHOST: begin
        inByteValid = hostByteValid;
        inByte = hostByte;
      end
      `RBL_MODE_EEPROM: begin
        inByteValid = eeByteValid;
        inByte = eeByte;
      end
      default: inByteValid = 1'b0;
    endcase
  end

  // reset config: bit 4 written by software, survives software reset
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      resetConfig <= 8'h00;
      swPend <= 1'b0;
    end else begin
      if (resetConfigWe)
        resetConfig[7:2] <= resetConfigWrite[7:2];
      if (state == ST_CAPTURE)
        resetConfig[1:0] <= pinSync;
      swPend <= softReset;
    end
  end

  assign lastBlock = (blkFlags[15] == 1'b1);

  // boot sequencer
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= ST_CAPTURE;
      bootMode <= 2'h0;
      hdrCnt <= 3'h0;
      blkAddr <= 32'h00000000;
      blkCount <= 16'h0000;
      blkFlags <= 16'h0000;
      holdFlag <= 6'h00;
      holdValid <= 1'b0;
      coreARun <= 1'b0;
      coreAStart <= 32'h00000000;
      coreAExtFetch <= 1'b0;
      fetch16 <= 1'b0;
      bootDone <= 1'b0;
      memWrite <= '0;
      memCfg <= '0;
      flashReadReq <= 1'b0;
      flashAddr <= 32'h00000000;
    end else if (swPend) begin
      coreARun <= 1'b0;
      bootDone <= 1'b0;
      memWrite <= '0;
      flashReadReq <= 1'b0;
      if (resetConfig[`RBL_RCFG_SKIP_BIT]) begin
        state <= ST_LAUNCH;
      end else begin
        state <= ST_CAPTURE;
      end
    end else begin
      memWrite.valid <= 1'b0;
      flashReadReq <= 1'b0;
      case (state)
        ST_CAPTURE: begin
          bootMode <= pinSync;
          state <= ST_DISPATCH;
        end
        ST_DISPATCH: begin
          hdrCnt <= 3'h0;
          holdValid <= 1'b0;
          case (bootMode)
            `RBL_MODE_DIRECT: begin
              memCfg <= '{`RBL_SETUP_CYC, `RBL_ACCESS_CYC,
                          `RBL_HOLD_CYC, `RBL_FLASH_BANK, 1'b1};
              coreAStart <= `RBL_DIRECT_ADDR;
              fetch16 <= 1'b1;
              coreAExtFetch <= 1'b1;
              coreARun <= 1'b1;
              bootDone <= 1'b1;
              state <= ST_RUN;
            end
            `RBL_MODE_FLASH: begin
              memCfg <= '{`RBL_SETUP_CYC, `RBL_ACCESS_CYC,
                          `RBL_HOLD_CYC, `RBL_FLASH_BANK, 1'b1};
              flashAddr <= 32'h00000000;
              flashReadReq <= 1'b1;
              state <= ST_HDR;
            end
            `RBL_MODE_EEPROM: state <= ST_EE_CMD;
            default: state <= ST_HDR;
          endcase
        end
        ST_EE_CMD: begin
          if (cmdBits == 6'h00 && sckDiv == 4'h0)
            state <= ST_HDR;
        end
        ST_HDR: begin
          // header: addr(4) count(2) flags(2), little endian
          if (inByteValid) begin
            hdrCnt <= hdrCnt + 3'h1;
            case (hdrCnt)
              3'h0: blkAddr[7:0] <= inByte;
              3'h1: blkAddr[15:8] <= inByte;
              3'h2: blkAddr[23:16] <= inByte;
              3'h3: blkAddr[31:24] <= inByte;
              3'h4: blkCount[7:0] <= inByte;
              3'h5: blkCount[15:8] <= inByte;
              3'h6: blkFlags[7:0] <= inByte;
              default: blkFlags[15:8] <= inByte;
            endcase
            if (hdrCnt == 3'h7) begin
              if (!holdValid) begin
                holdFlag <= {inByte[2:0], blkFlags[7:5]};
                holdValid <= 1'b1;
              end
              state <= ({inByte, blkFlags[7:0]} == 16'h0000 ||
                        blkCount == 16'h0000) ? ST_HDR : ST_DATA;
              if (blkCount == 16'h0000 && inByte[7])
                state <= ST_LAUNCH;
            end
          end
          if (bootMode == `RBL_MODE_FLASH && inByteValid) begin
            flashAddr <= flashAddr + 32'h1;
            flashReadReq <= 1'b1;
          end
        end
        ST_DATA: begin
          if (inByteValid) begin
            memWrite <= '{1'b1, blkAddr, inByte};
            blkAddr <= blkAddr + 32'h1;
            blkCount <= blkCount - 16'h1;
            if (blkCount == 16'h0001) begin
              hdrCnt <= 3'h0;
              state <= lastBlock ? ST_LAUNCH : ST_HDR;
            end
            if (bootMode == `RBL_MODE_FLASH) begin
              flashAddr <= flashAddr + 32'h1;
              flashReadReq <= 1'b1;
            end
          end
        end
        ST_LAUNCH: begin
          coreAStart <= `RBL_L1A_ADDR;
          coreAExtFetch <= 1'b0;
          fetch16 <= 1'b0;
          coreARun <= 1'b1;
          bootDone <= 1'b1;
          state <= ST_RUN;
        end
        ST_RUN: state <= ST_RUN;
        default: state <= ST_CAPTURE;
      endcase
    end
  end

  // second core waits for the first to clear the hold bit
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      coreBRun <= 1'b0;
      coreBStart <= 32'h00000000;
      coreBExtFetch <= 1'b0;
    end else begin
      coreBExtFetch <= 1'b0;
      if (swPend) begin
        coreBRun <= 1'b0;
      end else if (coreARun && !sysSync[1]) begin
        coreBRun <= 1'b1;
        coreBStart <= `RBL_L1B_ADDR;
      end
    end
  end

  // host-hold: busy unless waiting for a byte; the host must obey it
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      flagOut <= 64'h0;
      flagOeN <= {64{1'b1}};
    end else begin
      flagOut <= 64'h0;
      flagOeN <= {64{1'b1}};
      if (bootMode == `RBL_MODE_SPIHOST && holdValid && !bootDone) begin
        flagOeN[holdFlag] <= 1'b0;
        flagOut[holdFlag] <= memWrite.valid || hostByteValid ||
          !(state == ST_HDR || state == ST_DATA);
      end
    end
  end

  // eeprom master: mode 0, command then address, then read until launch
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      eeprom_select_flag <= 1'b1;
      eeSck <= 1'b0;
      eeMosi <= 1'b0;
      sckDiv <= 4'h0;
      cmdShift <= 32'h0;
      cmdBits <= 6'h00;
      eeShift <= 8'h00;
      eeBit <= 3'h0;
      eeByteValid <= 1'b0;
      eeByte <= 8'h00;
    end else begin
      eeByteValid <= 1'b0;
      if (swPend || bootMode != `RBL_MODE_EEPROM || bootDone ||
          state == ST_LAUNCH) begin
        eeprom_select_flag <= 1'b1;
        eeSck <= 1'b0;
        cmdBits <= 6'h00;
      end else if (state == ST_DISPATCH) begin
        eeprom_select_flag <= 1'b0;
        cmdShift <= eeAddr24 ? {`RBL_EE_READ_CMD, `RBL_EE_ADDR}
                    : {`RBL_EE_READ_CMD, 16'(`RBL_EE_ADDR), 8'h00};
        cmdBits <= eeAddr24 ? 6'h20 : 6'h18;
        sckDiv <= `RBL_SCK_DIV;
        eeBit <= 3'h0;
      end else if (sckDiv != 4'h0) begin
        sckDiv <= sckDiv - 4'h1;
        eeMosi <= cmdShift[31]; // mode 0: bit must stand before the rise
      end else begin
        sckDiv <= `RBL_SCK_DIV;
        if (!eeSck) begin
          eeSck <= 1'b1;
          if (cmdBits == 6'h00) begin // data starts right after last addr bit
            eeShift <= {eeShift[6:0], eeMiso};
            eeBit <= eeBit + 3'h1;
            if (eeBit == 3'h7) begin
              eeByte <= {eeShift[6:0], eeMiso};
              eeByteValid <= 1'b1;
            end
          end
        end else begin
          eeSck <= 1'b0;
          cmdShift <= {cmdShift[30:0], 1'b0};
          if (cmdBits != 6'h00)
            cmdBits <= cmdBits - 6'h1;
        end
      end
    end
  end
endmodule // rbl_boot_loader

// ===== dv/rbl_boot_chk.sv
// checker for the reset boot mode loader, sees only its top ports
// assumes binding to rbl_boot_loader and sys_clk as the only clock
`timescale 1ns/100ps
module rbl_boot_chk
  import rbl_pkg::*;
(
  input wire logic sys_clk, // system clock
  input wire logic rst_n, // async reset, active low
  input wire logic softReset, // software reset pulse
  input wire logic [7:0] core_a_system_config, // first core sysconfig
  input wire logic eeprom_select_flag, // eeprom select, active low
  input wire logic [63:0] flagOeN, // flag enables, low drives
  input wire rbl_wr_t memWrite, // load write
  input wire rbl_mem_cfg_t memCfg, // async memory timing
  input wire logic [1:0] bootMode, // captured mode
  input wire logic [7:0] resetConfig, // reset config readback
  input wire logic coreARun, // first core released
  input wire logic [31:0] coreAStart, // first core start
  input wire logic coreAExtFetch, // first core external fetch
  input wire logic fetch16, // 16-bit packing
  input wire logic coreBRun, // second core released
  input wire logic [31:0] coreBStart, // second core start
  input wire logic coreBExtFetch, // second core external fetch
  input wire logic bootDone // load finished
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // six cycles cover the two-stage sync plus the release register
  sequence s_b_held;
    (core_a_system_config[5] && !coreBRun && !softReset) [*6];
  endsequence
  sequence s_b_free;
    (coreARun && !core_a_system_config[5] && bootMode != 2'h0) [*8];
  endsequence
  a_cfg_slow_timing: assert property (memCfg.enable |->
    memCfg.setupCyc == 4'h4 && memCfg.accessCyc == 4'hf &&
    memCfg.holdCyc == 4'h3 && memCfg.bank == 2'h0)
    else $error("async timing not slowest");
  a_direct_fetch: assert property (
    coreARun && bootMode == 2'h0 && !resetConfig[4] |->
    coreAStart == 32'h20000000 && fetch16 && coreAExtFetch)
    else $error("direct start wrong");
  a_load_start: assert property (
    coreARun && bootMode != 2'h0 |-> coreAStart == 32'hffa00000)
    else $error("first core start wrong");
  a_b_no_ext: assert property (!coreBExtFetch)
    else $error("second core external fetch");
  a_b_start: assert property (coreBRun |-> coreBStart == 32'hff600000)
    else $error("second core start wrong");
  a_b_held: assert property (s_b_held |=> !coreBRun)
    else $error("second core released while held");
  a_b_release: assert property (s_b_free |-> coreBRun)
    else $error("second core not released");
  a_ee_select_held: assert property (
    !eeprom_select_flag && !bootDone && !softReset && !$past(softReset) |=>
    !eeprom_select_flag || bootDone)
    else $error("eeprom select dropped mid load");
  a_wr_needs_load: assert property (
    memWrite.valid |-> bootMode != 2'h0)
    else $error("load write in direct mode");
  a_hold_host_only: assert property (
    flagOeN != {64{1'b1}} |-> bootMode == 2'h2 || $past(bootMode) == 2'h2)
    else $error("flag driven outside host mode");
  a_ee_mode_select: assert property (
    !eeprom_select_flag |-> bootMode == 2'h3 || $past(bootMode) == 2'h3)
    else $error("eeprom select outside eeprom mode");
endmodule // rbl_boot_chk
bind rbl_boot_loader rbl_boot_chk rbl_boot_chk_inst (.sys_clk, .rst_n,
  .softReset, .core_a_system_config, .eeprom_select_flag, .flagOeN,
  .memWrite, .memCfg, .bootMode, .resetConfig, .coreARun, .coreAStart,
  .coreAExtFetch, .fetch16, .coreBRun, .coreBStart, .coreBExtFetch,
  .bootDone);

// ===== dv/rbl_host_model.sv
// spi host model: masters the load transfer, mode 0, msb first
// assumes holdLvl is the host-hold pin level, low when undriven
`timescale 1ns/100ps
module rbl_host_model (
  output logic hostSpiClk, // serial clock, still between frames
  output logic hostSelectN, // slave select, active low
  output logic hostMosi, // serial data
  input wire logic holdLvl // host-hold pin level
);
  initial begin
    hostSpiClk = 1'b0;
    hostSelectN = 1'b1;
    hostMosi = 1'b0;
  end
  // gapNs lets the bench answer promptly or slowly
  task automatic send_byte(input logic [7:0] b, input int gapNs,
                           output logic late);
    int n;
    n = 0;
    #(gapNs);
    while (holdLvl && n < 4000) begin
      #100;
      n++;
    end
    // a hold that never lifts is reported to the caller
    late = (n >= 4000);
    hostSelectN = 1'b0;
    for (int i = 7; i >= 0; i--) begin
      hostMosi = b[i];
      #62.5 hostSpiClk = 1'b1;
      #62.5 hostSpiClk = 1'b0;
    end
    #62.5 hostSelectN = 1'b1;
    // a released line must not keep showing the last bit
    hostMosi = ~hostMosi;
  endtask
endmodule // rbl_host_model

// ===== dv/tb.sv
// self-checking bench for the reset boot mode loader
// assumes the host model and checker are compiled before it
`timescale 1ns/100ps
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin \
  fail_count++; \
  $display("mismatch t=%0t got=%h exp=%h", $time, (g), (e)); end end
`define WAITC(c) begin wcnt = 0; while (!(c) && wcnt < 20000) begin \
  @(posedge sys_clk); #1; wcnt++; end \
  if (!(c)) begin fail_count++; report_and_stop(); end end
module tb;
  import rbl_pkg::*;
  logic sys_clk = 1'b0, rst_n = 1'b0, softReset = 1'b0, rcfgWe = 1'b0;
  logic [1:0] pins = 2'h2;
  logic [7:0] sysCfg = 8'h20, rcfgW = 8'h00, flashByte = 8'h00;
  logic eeAddr24 = 1'b0, eeMiso = 1'b0, flashByteValid = 1'b0;
  logic [31:0] seed = 32'h77f40789, flashAddr, coreAStart, coreBStart, bits;
  logic flashReadReq, eeSck, eeMosi, eeprom_select_flag, coreARun;
  logic coreAExtFetch, fetch16, coreBRun, coreBExtFetch, bootDone;
  logic hostSpiClk, hostSelectN, hostMosi, late;
  logic [63:0] flagOut, flagOeN;
  logic [1:0] bootMode;
  logic [7:0] resetConfig;
  logic [7:0] img [10];
  logic [7:0] fImg [16];
  logic [39:0] expWr;
  logic [39:0] expQ [$];
  rbl_wr_t memWrite;
  rbl_mem_cfg_t memCfg;
  int fail_count = 0, total_checks = 0, wcnt;
  always #20 sys_clk = ~sys_clk;
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  always @(posedge sys_clk) begin
    seed <= lfsr(seed);
    eeMiso <= seed[0];
    flashByteValid <= flashReadReq;
    flashByte <= fImg[flashAddr[3:0]];
  end
  always @(posedge sys_clk) begin
    if (memWrite.valid === 1'b1) begin
      expWr = expQ.size() ? expQ.pop_front() : 'x;
      `CHK({memWrite.addr, memWrite.data}, expWr)
    end
  end
  rbl_host_model rbl_host_model_inst (.hostSpiClk(hostSpiClk),
    .hostSelectN(hostSelectN), .hostMosi(hostMosi),
    .holdLvl(!flagOeN[7] && flagOut[7]));
  rbl_boot_loader rbl_boot_loader_inst (.sys_clk(sys_clk), .rst_n(rst_n),
    .softReset(softReset), .boot_select_pins(pins),
    .core_a_system_config(sysCfg), .resetConfigWrite(rcfgW),
    .resetConfigWe(rcfgWe), .eeAddr24(eeAddr24), .hostSpiClk(hostSpiClk),
    .hostSelectN(hostSelectN), .hostMosi(hostMosi), .eeMiso(eeMiso),
    .flashByteValid(flashByteValid), .flashByte(flashByte),
    .flashReadReq(flashReadReq), .flashAddr(flashAddr), .eeSck(eeSck),
    .eeMosi(eeMosi), .eeprom_select_flag(eeprom_select_flag),
    .flagOut(flagOut), .flagOeN(flagOeN), .memWrite(memWrite),
    .memCfg(memCfg), .bootMode(bootMode), .resetConfig(resetConfig),
    .coreARun(coreARun), .coreAStart(coreAStart),
    .coreAExtFetch(coreAExtFetch), .fetch16(fetch16), .coreBRun(coreBRun),
    .coreBStart(coreBStart), .coreBExtFetch(coreBExtFetch),
    .bootDone(bootDone));
  task report_and_stop;
    $display("checks=%0d mismatches=%0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task do_reset(input logic [1:0] m);
    @(posedge sys_clk);
    rst_n <= 1'b0;
    pins <= m;
    repeat (6) @(posedge sys_clk);
    `CHK(flagOeN, {64{1'b1}})
    `CHK(eeprom_select_flag, 1'b1)
    rst_n <= 1'b1;
    repeat (4) @(posedge sys_clk);
    #1;
    `CHK(resetConfig[1:0], m)
  endtask
  // pins settle well before the pulse, as the capture is synchronised
  task soft_reset(input logic [1:0] m, input logic [7:0] c);
    @(posedge sys_clk);
    pins <= m;
    rcfgW <= c;
    rcfgWe <= 1'b1;
    @(posedge sys_clk);
    rcfgWe <= 1'b0;
    repeat (3) @(posedge sys_clk);
    softReset <= 1'b1;
    @(posedge sys_clk);
    softReset <= 1'b0;
    repeat (3) @(posedge sys_clk);
    #1;
  endtask
  initial begin
    img = '{8'h00, 8'h10, 8'h00, 8'h00, 8'h02, 8'h00, 8'he0, 8'h80,
      seed[7:0], seed[15:8]};
    fImg = '{8'h00, 8'h30, 8'h00, 8'h00, 8'h01, 8'h00, 8'h00, 8'h80,
      seed[23:16], 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    do_reset(2'h2);
    for (int i = 0; i < 10; i++) begin
      if (i == 8) begin
        repeat (10) @(posedge sys_clk);
        #1;
        `CHK({flagOeN[7:6], flagOut[7]}, 3'h2)
      end
      if (i >= 8) expQ.push_back({32'h00001000 + i - 8, img[i]});
      rbl_host_model_inst.send_byte(img[i], (i < 8) ? 200 : 2000, late);
      `CHK(late, 1'b0)
      if (late) report_and_stop();
    end
    `WAITC(coreARun === 1'b1)
    `CHK(coreAStart, 32'hffa00000)
    `CHK(bootMode, 2'h2)
    repeat (8) @(posedge sys_clk);
    `CHK(coreBRun, 1'b0)
    sysCfg <= 8'h00;
    `WAITC(coreBRun === 1'b1)
    `CHK(coreBStart, 32'hff600000)
    sysCfg <= 8'h20;
    soft_reset(2'h2, 8'h10);
    `WAITC(coreARun === 1'b1)
    `CHK({resetConfig[4], coreAStart}, {1'b1, 32'hffa00000})
    do_reset(2'h0);
    `WAITC(coreARun === 1'b1)
    `CHK({coreAStart, fetch16, coreAExtFetch}, {32'h20000000, 2'h3})
    `CHK(memCfg[14:1], {4'h4, 4'hf, 4'h3, 2'h0})
    `CHK(coreBExtFetch, 1'b0)
    expQ.push_back({32'h00003000, fImg[8]});
    soft_reset(2'h1, 8'h00);
    `WAITC(bootDone === 1'b1)
    `CHK({bootMode, memCfg.bank, flashAddr}, {4'h4, 32'h9})
    eeAddr24 <= seed[3];
    soft_reset(2'h3, 8'h00);
    `WAITC(eeprom_select_flag === 1'b0)
    bits = 32'h0;
    for (int k = 0; k < (eeAddr24 ? 32 : 24); k++) begin
      `WAITC(eeSck === 1'b1)
      bits = {bits[30:0], eeMosi};
      `WAITC(eeSck === 1'b0)
    end
    `CHK(bits, eeAddr24 ? 32'h03000000 : 32'h00030000)
    `CHK(expQ.size(), 0)
    report_and_stop();
  end
endmodule // tb
